/* File: hw/lmrm_pkg.sv */
package lmrm_pkg;

  // ------------------------------------------------------------
  // widths and password codes
  // ------------------------------------------------------------
  localparam int          DATA_W       = 16;           // register word width
  localparam int          CFG_N        = 17;           // setpoints plus parameters
  localparam int          CFG_IDX_W    = 5;            // config index width
  localparam int          ERR_W        = 6;            // error flag count
  localparam int          OUT_W        = 3;            // output state bits
  localparam logic [15:0] PW_LEGACY    = 16'h0079;     // password selecting legacy map
  localparam logic [15:0] PW_NATIVE    = 16'h007c;     // password restoring native map
  localparam logic [15:0] FACTORY_KEY  = 16'h03e7;     // value that reloads defaults
  localparam logic [15:0] ALARM_KEY    = 16'h0001;     // value that clears alarms
  localparam logic [15:0] WORD_RST     = 16'h0000;     // reset value of words
  localparam logic [7:0]  EXC_NONE     = 8'h00;        // no exception
  localparam logic [7:0]  EXC_ILL_ADDR = 8'h02;        // illegal data address

  // ------------------------------------------------------------
  // legacy map addresses
  // ------------------------------------------------------------
  localparam logic [15:0] A_DEV_TYPE   = 16'h0000;
  localparam logic [15:0] A_SW_VER     = 16'h0001;
  localparam logic [15:0] A_RSVD_2     = 16'h0002;
  localparam logic [15:0] A_RSVD_3     = 16'h0003;
  localparam logic [15:0] A_RSVD_4     = 16'h0004;
  localparam logic [15:0] A_SLAVE_ADR  = 16'h0005;
  localparam logic [15:0] A_RSVD_6     = 16'h0006;
  localparam logic [15:0] A_AUTO_ADR   = 16'h0032;
  localparam logic [15:0] A_PLANT_CMP  = 16'h0033;
  localparam logic [15:0] A_FACTORY    = 16'h01f4;
  localparam logic [15:0] A_PROCESS    = 16'h03e8;
  localparam logic [15:0] A_COLD_JCT   = 16'h03e9;
  localparam logic [15:0] A_SETPT_1    = 16'h03ea;
  localparam logic [15:0] A_SETPT_2    = 16'h03eb;
  localparam logic [15:0] A_HEAT_PCT   = 16'h03ec;
  localparam logic [15:0] A_COOL_PCT   = 16'h03ed;
  localparam logic [15:0] A_OUT_STATE  = 16'h03ee;
  localparam logic [15:0] A_ALARM_CLR  = 16'h03ef;
  localparam logic [15:0] A_ERR_FLAGS  = 16'h03f0;
  localparam logic [15:0] A_RUN_CTRL   = 16'h03f1;
  localparam logic [15:0] A_OFFLINE    = 16'h03f2;

  // config word addresses: setpoints then parameters, index order
  localparam logic [CFG_N*16-1:0] CFG_ADDRS = {
    16'h07eb, 16'h07e6, 16'h07e5, 16'h07e4, 16'h07e3, 16'h07e2, 16'h07e1, 16'h07e0,
    16'h07df, 16'h07dd, 16'h07dc, 16'h07db, 16'h07d3, 16'h07d2, 16'h07d1,
    A_SETPT_2, A_SETPT_1};

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic        wr;     // 1 write, 0 read
    logic [15:0] addr;   // register address
    logic [15:0] wdata;  // write data
  } lmrm_req_t;

  typedef struct packed {
    logic        ack;    // answer strobe
    logic [7:0]  exc;    // exception code, zero when none
    logic [15:0] rdata;  // read data
  } lmrm_resp_t;

  typedef struct packed {
    logic [15:0] process;   // process reading
    logic [15:0] cold_jct;  // cold junction reading
    logic [15:0] heat_pct;  // heating output 0..10000
    logic [15:0] cool_pct;  // cooling output 0..10000
  } lmrm_meas_t;

  typedef struct packed {
    logic              valid;  // address is a config word
    logic [CFG_IDX_W-1:0] idx; // its index
  } lmrm_cfg_hit_t;

endpackage

/* File: hw/lmrm_legacy_map.sv */
`timescale 1ns/1ps
// Summary of operation
// - password 121 selects legacy register map
// - password 124 restores native register map
// - writing 999 at 500 reloads defaults
// - heating percentage read-only at 1004, reset 0
// - cooling percentage read-only at 1005, reset 0
// - 1006 shows relay and solid-state output bits
// - writing 1 at 1007 clears all alarms
// - 1008 reports six read-only error flags
// - 1009 run control, 0 stop, 1 run
// - 1010 holds offline time in milliseconds
// - wireless config waits for restart before use
module lmrm_legacy_map #(
  parameter logic [15:0] DEV_TYPE_ID = 16'h00a5,  // arbitrary identity value
  parameter logic [15:0] SW_VERSION  = 16'h0100   // arbitrary version value
) (
  // clock and reset
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_resetn,
  // front panel password entry
  input  wire logic                         i_pw_stb,
  input  wire logic [15:0]                  i_pw_value,
  // register access from the serial slave
  input  wire logic                         i_req_valid,
  input  wire lmrm_pkg::lmrm_req_t          i_req,
  output lmrm_pkg::lmrm_resp_t              o_resp,
  // live device state
  input  wire lmrm_pkg::lmrm_meas_t         i_meas,
  input  wire logic [lmrm_pkg::OUT_W-1:0]   i_out_state,
  input  wire logic [lmrm_pkg::ERR_W-1:0]   i_err_flags,
  input  wire logic [15:0]                  i_slave_addr,
  // wireless configuration writes and restart
  input  wire logic                         i_nfc_wr,
  input  wire logic [lmrm_pkg::CFG_IDX_W-1:0] i_nfc_idx,
  input  wire logic [15:0]                  i_nfc_data,
  input  wire logic                         i_restart,
  // control outputs
  output logic                              o_legacy_map,
  output logic                              o_factory_load,
  output logic                              o_alarm_clear,
  output logic                              o_run,
  output logic [15:0]                       o_offline_ms,
  output logic [lmrm_pkg::OUT_W-1:0]        o_out_cmd,
  output logic                              o_auto_addr_stb,
  output logic                              o_plant_cmp_stb,
  output logic [15:0]                       o_cmd_data,
  output logic                              o_restart_req,
  output logic [lmrm_pkg::CFG_N*16-1:0]     o_cfg
);
  import lmrm_pkg::*;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  // config word lookup, shared by read and write paths
  // small table, so a parallel compare is cheap
  // addresses in the table never repeat
  function automatic lmrm_cfg_hit_t cfg_lookup(input logic [15:0] addr);
    lmrm_cfg_hit_t hit;
    hit = '0;
    for (int k = 0; k < CFG_N; k++) begin
      if (CFG_ADDRS[k*16 +: 16] == addr) begin
        hit.valid = 1'b1;
        hit.idx   = CFG_IDX_W'(k);
      end
    end
    return hit;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  // all state takes a synchronous reset
  logic                  legacy_ff;          // legacy map selected
  logic [15:0]           factory_ff;         // last word at 500
  logic [15:0]           alarm_word_ff;      // last word at 1007
  logic                  run_ff;             // regulation running
  logic [15:0]           offline_ff;         // offline time
  logic [OUT_W-1:0]      out_cmd_ff;         // output command bits
  logic                  factory_pulse_ff;   // default reload strobe
  logic                  alarm_pulse_ff;     // alarm clear strobe
  logic                  auto_stb_ff;        // auto addressing strobe
  logic                  plant_stb_ff;       // plant code strobe
  logic [15:0]           cmd_data_ff;        // data for those strobes
  logic                  restart_req_ff;     // pending restart flag
  lmrm_resp_t            resp_ff;            // answer register
  logic [15:0]           cfg_act_ff [CFG_N]; // configuration in use
  logic [15:0]           cfg_new_ff [CFG_N]; // configuration awaiting restart

  // ------------------------------------------------------------
  // request decode
  // ------------------------------------------------------------
  lmrm_cfg_hit_t         hit;                // config address match
  logic                  acc;                // accepted access
  logic                  wr_ok;              // write to a writable word
  logic                  rd_ok;              // read of a readable word
  logic [15:0]           nxt_rdata;          // read mux result

  assign hit = cfg_lookup(i_req.addr);
  // native map: the block stays silent on the bus
  // so another slave may answer instead
  assign acc = i_req_valid && legacy_ff;

  // address classification and read mux
  // defaults: readable, not writable, reads zero
  // a refused access must leave no side effect
  always_comb begin
    wr_ok     = 1'b0;
    rd_ok     = 1'b1;
    nxt_rdata = WORD_RST;
    case (i_req.addr)
      // identity and reserved words, read-only
      A_DEV_TYPE:  nxt_rdata = DEV_TYPE_ID;
      A_SW_VER:    nxt_rdata = SW_VERSION;
      A_RSVD_2, A_RSVD_3, A_RSVD_4, A_RSVD_6: nxt_rdata = WORD_RST;
      A_SLAVE_ADR: nxt_rdata = i_slave_addr;
      // write-only command words, then the default reload word
      // a read of the first two answers illegal address
      A_AUTO_ADR, A_PLANT_CMP: begin
        wr_ok = 1'b1;
        rd_ok = 1'b0;
      end
      A_FACTORY: begin
        wr_ok     = 1'b1;
        nxt_rdata = factory_ff;
      end
      // live readings and control words; 1000, 1001, 1004, 1005 and 1008 read-only
      A_PROCESS:   nxt_rdata = i_meas.process;
      A_COLD_JCT:  nxt_rdata = i_meas.cold_jct;
      A_HEAT_PCT:  nxt_rdata = i_meas.heat_pct;
      A_COOL_PCT:  nxt_rdata = i_meas.cool_pct;
      A_OUT_STATE: begin
        wr_ok     = 1'b1;
        nxt_rdata = 16'(i_out_state);
      end
      A_ALARM_CLR: begin
        wr_ok     = 1'b1;
        nxt_rdata = alarm_word_ff;
      end
      A_ERR_FLAGS: nxt_rdata = 16'(i_err_flags);
      A_RUN_CTRL: begin
        wr_ok     = 1'b1;
        nxt_rdata = 16'(run_ff);
      end
      A_OFFLINE: begin
        wr_ok     = 1'b1;
        nxt_rdata = offline_ff;
      end
      default: begin
        // config words, otherwise unmapped
        wr_ok     = hit.valid;
        rd_ok     = hit.valid;
        nxt_rdata = hit.valid ? cfg_act_ff[hit.idx] : WORD_RST;
      end
    endcase
  end

  // only accepted writes to writable words count
  // every bus-write side effect below hangs off this term
  logic                  do_wr;              // write that takes effect
  assign do_wr = acc && i_req.wr && wr_ok;

  // ------------------------------------------------------------
  // map selection
  // ------------------------------------------------------------
  // password strobes switch the visible map
  // other password values leave the map alone
  // the choice holds until the other password
  // or a reset, which returns to native
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      legacy_ff <= 1'b0;
    end else if (i_pw_stb && i_pw_value == PW_LEGACY) begin
      legacy_ff <= 1'b1;
    end else if (i_pw_stb && i_pw_value == PW_NATIVE) begin
      legacy_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // answer path
  // ------------------------------------------------------------
  // one answer per accepted request, next cycle
  // refused access still answered, with exception
  // rdata zero unless a good read was taken
  // back-to-back requests give back-to-back answers
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      resp_ff <= '0;
    end else begin
      resp_ff.ack <= acc;
      if (acc && (i_req.wr ? !wr_ok : !rd_ok)) begin
        resp_ff.exc   <= EXC_ILL_ADDR;
        resp_ff.rdata <= WORD_RST;
      end else begin
        resp_ff.exc   <= EXC_NONE;
        resp_ff.rdata <= (acc && !i_req.wr) ? nxt_rdata : WORD_RST;
      end
    end
  end

  // ------------------------------------------------------------
  // default reload and alarm clear
  // ------------------------------------------------------------
  // key words raise one-cycle strobes
  // strobes last one cycle; act on that edge
  // a non-key word is stored, raises nothing
  // stored words read back what was written
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      factory_ff       <= WORD_RST;
      factory_pulse_ff <= 1'b0;
      alarm_word_ff    <= WORD_RST;
      alarm_pulse_ff   <= 1'b0;
    end else begin
      factory_pulse_ff <= do_wr && i_req.addr == A_FACTORY && i_req.wdata == FACTORY_KEY;
      alarm_pulse_ff   <= do_wr && i_req.addr == A_ALARM_CLR && i_req.wdata == ALARM_KEY;
      if (do_wr && i_req.addr == A_FACTORY) begin
        factory_ff <= i_req.wdata;
      end
      if (do_wr && i_req.addr == A_ALARM_CLR) begin
        alarm_word_ff <= i_req.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // run, offline time and output command
  // ------------------------------------------------------------
  // plain read/write control words
  // 1006 writes drive the command bits, reads
  // still show the live output states
  // only bit 0 of the run word is kept
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      run_ff     <= 1'b0;
      offline_ff <= WORD_RST;
      out_cmd_ff <= '0;
    end else if (do_wr) begin
      case (i_req.addr)
        A_RUN_CTRL:  run_ff     <= i_req.wdata[0];
        A_OFFLINE:   offline_ff <= i_req.wdata;
        A_OUT_STATE: out_cmd_ff <= i_req.wdata[OUT_W-1:0];
        default: begin
          // other words handled elsewhere
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // write-only command words
  // ------------------------------------------------------------
  // addressing commands forwarded as strobes
  // these words have no read value
  // data holds until the next command word
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      auto_stb_ff  <= 1'b0;
      plant_stb_ff <= 1'b0;
      cmd_data_ff  <= WORD_RST;
    end else begin
      auto_stb_ff  <= do_wr && i_req.addr == A_AUTO_ADR;
      plant_stb_ff <= do_wr && i_req.addr == A_PLANT_CMP;
      if (do_wr && (i_req.addr == A_AUTO_ADR || i_req.addr == A_PLANT_CMP)) begin
        cmd_data_ff <= i_req.wdata;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration words
  // ------------------------------------------------------------
  // serial writes take effect at once; wireless ones wait
  // one active and one pending copy per word
  // a serial write updates both copies, pending only if no wireless write hits it that cycle
  // a wireless write only touches pending
  // a serial write beats restart for its word
  for (genvar g = 0; g < CFG_N; g++) begin : g_cfg
    logic ser_hit;                                // serial write to this word
    logic nfc_hit;                                // wireless write to this word
    assign ser_hit = do_wr && hit.valid && hit.idx == CFG_IDX_W'(g);
    assign nfc_hit = i_nfc_wr && i_nfc_idx == CFG_IDX_W'(g);

    // word in use
    always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
        cfg_act_ff[g] <= WORD_RST;
      end else if (ser_hit) begin
        cfg_act_ff[g] <= i_req.wdata;
      end else if (i_restart) begin
        cfg_act_ff[g] <= cfg_new_ff[g];
      end
    end

    // word awaiting restart
    always_ff @(posedge i_ref_clk) begin
      if (!i_resetn) begin
        cfg_new_ff[g] <= WORD_RST;
      end else if (nfc_hit) begin
        cfg_new_ff[g] <= i_nfc_data;
      end else if (ser_hit) begin
        cfg_new_ff[g] <= i_req.wdata;
      end
    end

    assign o_cfg[g*16 +: 16] = cfg_act_ff[g];
  end

  // restart request: set by wireless write, cleared by restart, set wins
  // index past the table requests nothing
  // a write in the restart cycle keeps it set
  // so the next restart applies that word
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      restart_req_ff <= 1'b0;
    end else if (i_nfc_wr && i_nfc_idx < CFG_IDX_W'(CFG_N)) begin
      restart_req_ff <= 1'b1;
    end else if (i_restart) begin
      restart_req_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // every output is taken from a register
  // o_cfg is driven inside the config loop
  assign o_resp          = resp_ff;
  assign o_legacy_map    = legacy_ff;
  assign o_factory_load  = factory_pulse_ff;
  assign o_alarm_clear   = alarm_pulse_ff;
  assign o_run           = run_ff;
  assign o_offline_ms    = offline_ff;
  assign o_out_cmd       = out_cmd_ff;
  assign o_auto_addr_stb = auto_stb_ff;
  assign o_plant_cmp_stb = plant_stb_ff;
  assign o_cmd_data      = cmd_data_ff;
  assign o_restart_req   = restart_req_ff;

endmodule

/* File: sim/lmrm_map_sva.sv */
`timescale 1ns/1ps
module lmrm_map_sva (
  // clock and reset
  input wire logic                            i_ref_clk,
  input wire logic                            i_resetn,
  // stimulus at the ports
  input wire logic                            i_pw_stb,
  input wire logic [15:0]                     i_pw_value,
  input wire logic                            i_req_valid,
  input wire lmrm_pkg::lmrm_req_t             i_req,
  input wire lmrm_pkg::lmrm_meas_t            i_meas,
  input wire logic [lmrm_pkg::OUT_W-1:0]      i_out_state,
  input wire logic [lmrm_pkg::ERR_W-1:0]      i_err_flags,
  input wire logic                            i_nfc_wr,
  input wire logic [lmrm_pkg::CFG_IDX_W-1:0]  i_nfc_idx,
  input wire logic                            i_restart,
  // design outputs
  input wire lmrm_pkg::lmrm_resp_t            o_resp,
  input wire logic                            o_legacy_map,
  input wire logic                            o_factory_load,
  input wire logic                            o_alarm_clear,
  input wire logic                            o_run,
  input wire logic                            o_restart_req,
  input wire logic [lmrm_pkg::CFG_N*16-1:0]   o_cfg
);
  import lmrm_pkg::*;
  // ----------------------------------------
  // taken requests
  // ----------------------------------------
  wire logic rd = i_req_valid && o_legacy_map && !i_req.wr;  // read taken
  wire logic wr = i_req_valid && o_legacy_map && i_req.wr;   // write taken
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  legacy_select_a: assert property (i_pw_stb && i_pw_value == PW_LEGACY |=> o_legacy_map)
    else $error("legacy map not selected");
  native_select_a: assert property (i_pw_stb && i_pw_value == PW_NATIVE |=> !o_legacy_map ##1 !o_resp.ack)
    else $error("native map not restored");
  factory_load_a: assert property (wr && i_req.addr == A_FACTORY && i_req.wdata == FACTORY_KEY |=> o_factory_load)
    else $error("default reload missing");
  heat_read_a: assert property (rd && i_req.addr == A_HEAT_PCT |=> o_resp.ack && o_resp.rdata == $past(i_meas.heat_pct))
    else $error("heating read wrong");
  cool_read_a: assert property (rd && i_req.addr == A_COOL_PCT |=> o_resp.rdata == $past(i_meas.cool_pct))
    else $error("cooling read wrong");
  out_read_a: assert property (rd && i_req.addr == A_OUT_STATE |=> o_resp.rdata == {13'h0, $past(i_out_state)})
    else $error("output state read wrong");
  alarm_pulse_a: assert property (o_alarm_clear |-> $past(wr) && $past(i_req.addr) == A_ALARM_CLR)
    else $error("alarm clear without write");
  err_read_a: assert property (rd && i_req.addr == A_ERR_FLAGS |=> o_resp.rdata == {10'h0, $past(i_err_flags)})
    else $error("error flags read wrong");
  run_write_a: assert property (wr && i_req.addr == A_RUN_CTRL |=> o_run == $past(i_req.wdata[0]))
    else $error("run control not updated");
  cfg_hold_a: assert property (!i_restart && !wr |=> $stable(o_cfg))
    else $error("config changed before restart");
  restart_req_a: assert property (i_nfc_wr && i_nfc_idx < CFG_N |=> o_restart_req)
    else $error("restart not requested");
  bad_addr_a: assert property ((rd && i_req.addr == A_AUTO_ADR) || (wr && i_req.addr == A_HEAT_PCT)
    |=> o_resp.ack && o_resp.exc == EXC_ILL_ADDR)
    else $error("illegal address not flagged");
endmodule
bind lmrm_legacy_map lmrm_map_sva chk (.i_ref_clk, .i_resetn, .i_pw_stb, .i_pw_value, .i_req_valid, .i_req,
  .i_meas, .i_out_state, .i_err_flags, .i_nfc_wr, .i_nfc_idx, .i_restart, .o_resp, .o_legacy_map,
  .o_factory_load, .o_alarm_clear, .o_run, .o_restart_req, .o_cfg);

/* File: sim/lmrm_master.sv */
`timescale 1ns/1ps
module lmrm_master (
  // clock
  input  wire logic                 i_ref_clk,
  // requests toward the register map
  output logic                      o_req_valid,
  output lmrm_pkg::lmrm_req_t       o_req,
  // answers from the register map
  input  wire lmrm_pkg::lmrm_resp_t i_resp
);
  import lmrm_pkg::*;
  initial begin
    o_req_valid = 1'b0;
    o_req       = '0;
  end
  // one word per request, answer sampled 1 ns after the taking edge
  task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] rdata, output logic [7:0] exc, output logic got);
    @(posedge i_ref_clk);
    #1;
    o_req_valid = 1'b1;
    o_req       = '{wr: w, addr: a, wdata: d};
    @(posedge i_ref_clk);
    #1;
    // released lines show the inverse so stale fields never look valid
    o_req_valid = 1'b0;
    o_req       = ~o_req;
    got         = i_resp.ack;
    exc         = i_resp.exc;
    rdata       = i_resp.rdata;
  endtask
endmodule

/* File: sim/legacy_modbus_register_map_test.sv */
`timescale 1ns/1ps
module legacy_modbus_register_map_test;
  import lmrm_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [15:0] DEV_ID = 16'h005a;  // arbitrary identity value
  logic i_ref_clk, i_resetn, i_pw_stb, i_nfc_wr, i_restart, i_req_valid, got;
  logic o_legacy_map, o_factory_load, o_alarm_clear, o_run, o_restart_req, o_auto_addr_stb, o_plant_cmp_stb;
  logic [15:0]          i_pw_value, i_nfc_data, rdata, o_offline_ms, o_cmd_data;
  logic [7:0]           exc;
  logic [4:0]           i_nfc_idx;
  logic [OUT_W-1:0]     i_out_state, o_out_cmd;
  logic [ERR_W-1:0]     i_err_flags;
  logic [CFG_N*16-1:0]  o_cfg;
  lmrm_req_t            i_req;
  lmrm_resp_t           o_resp;
  lmrm_meas_t           i_meas;
  int                   miscompares = 0, n_tests = 0, n_factory = 0, n_alarm = 0, n_auto = 0, n_plant = 0;
  lmrm_legacy_map #(.DEV_TYPE_ID(DEV_ID)) dut (.i_ref_clk, .i_resetn, .i_pw_stb, .i_pw_value, .i_req_valid,
    .i_req, .o_resp, .i_meas, .i_out_state, .i_err_flags, .i_slave_addr(16'h0011), .i_nfc_wr, .i_nfc_idx,
    .i_nfc_data, .i_restart, .o_legacy_map, .o_factory_load, .o_alarm_clear, .o_run, .o_offline_ms,
    .o_out_cmd, .o_auto_addr_stb, .o_plant_cmp_stb, .o_cmd_data, .o_restart_req, .o_cfg);
  lmrm_master m (.i_ref_clk, .o_req_valid(i_req_valid), .o_req(i_req), .i_resp(o_resp));
  // ----------------------------------------
  // clock, pulse counters, watchdog
  // ----------------------------------------
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    if (o_factory_load === 1'b1) n_factory++;
    if (o_alarm_clear === 1'b1) n_alarm++;
    if (o_auto_addr_stb === 1'b1) n_auto++;
    if (o_plant_cmp_stb === 1'b1) n_plant++;
  end
  initial begin
    #(4 * 5000);
    miscompares++;
    test_done();
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
    n_tests++;
    if (seen !== expv) begin
      miscompares++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask
  // register read or write with expected exception and data
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [7:0] x);
    m.access(w, a, d, rdata, exc, got);
    chk({15'h0, got}, 16'h0001);
    chk({8'h0, exc}, {8'h0, x});
    if (!w) chk(rdata, d);
    else chk(rdata, 16'h0);
  endtask
  task automatic pulse(input int sel, input logic [15:0] v, input logic [4:0] idx);
    @(posedge i_ref_clk);
    #1;
    {i_pw_stb, i_nfc_wr, i_restart} = 3'b100 >> sel;
    {i_pw_value, i_nfc_data, i_nfc_idx} = {v, v, idx};
    @(posedge i_ref_clk);
    #1;
    {i_pw_stb, i_nfc_wr, i_restart} = 3'b000;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_pw_stb, i_nfc_wr, i_restart, i_pw_value, i_nfc_data, i_nfc_idx} = '0;
    i_resetn = 1'b0;
    i_meas = '{process: 16'h0123, cold_jct: 16'h00fa, heat_pct: 16'h2710, cool_pct: 16'h0001};
    i_out_state = 3'b101;
    i_err_flags = 6'h2a;
    repeat (20) @(posedge i_ref_clk);
    #1 i_resetn = 1'b1;
    m.access(1'b0, A_HEAT_PCT, 16'h0, rdata, exc, got);
    chk({15'h0, got}, 16'h0);
    pulse(0, 16'h007b, 5'h0);
    chk({15'h0, o_legacy_map}, 16'h0);
    pulse(0, PW_LEGACY, 5'h0);
    chk({15'h0, o_legacy_map}, 16'h0001);
    xfer(1'b0, A_HEAT_PCT, 16'h2710, EXC_NONE);
    xfer(1'b0, A_COOL_PCT, 16'h0001, EXC_NONE);
    xfer(1'b0, A_OUT_STATE, 16'h0005, EXC_NONE);
    xfer(1'b0, A_ERR_FLAGS, 16'h002a, EXC_NONE);
    xfer(1'b0, A_RUN_CTRL, 16'h0, EXC_NONE);
    xfer(1'b0, A_OFFLINE, 16'h0, EXC_NONE);
    xfer(1'b0, A_FACTORY, 16'h0, EXC_NONE);
    xfer(1'b0, A_DEV_TYPE, DEV_ID, EXC_NONE);
    xfer(1'b0, A_SLAVE_ADR, 16'h0011, EXC_NONE);
    xfer(1'b1, 16'h07d1, 16'h0abc, EXC_NONE);
    chk(o_cfg[47:32], 16'h0abc);
    xfer(1'b0, 16'h07d1, 16'h0abc, EXC_NONE);
    i_out_state = 3'b010;
    xfer(1'b0, A_OUT_STATE, 16'h0002, EXC_NONE);
    xfer(1'b1, A_RUN_CTRL, 16'h0001, EXC_NONE);
    chk({15'h0, o_run}, 16'h0001);
    xfer(1'b0, A_RUN_CTRL, 16'h0001, EXC_NONE);
    xfer(1'b1, A_OFFLINE, 16'hbeef, EXC_NONE);
    chk(o_offline_ms, 16'hbeef);
    xfer(1'b1, A_FACTORY, 16'h03e6, EXC_NONE);
    xfer(1'b1, A_ALARM_CLR, 16'h0002, EXC_NONE);
    xfer(1'b1, A_FACTORY, FACTORY_KEY, EXC_NONE);
    xfer(1'b1, A_ALARM_CLR, ALARM_KEY, EXC_NONE);
    @(posedge i_ref_clk);
    #1;
    chk(16'(n_factory), 16'h0001);
    chk(16'(n_alarm), 16'h0001);
    xfer(1'b1, A_HEAT_PCT, 16'h1234, EXC_ILL_ADDR);
    xfer(1'b0, A_HEAT_PCT, 16'h2710, EXC_NONE);
    xfer(1'b0, A_AUTO_ADR, 16'h0, EXC_ILL_ADDR);
    xfer(1'b1, 16'h0007, 16'h5555, EXC_ILL_ADDR);
    xfer(1'b1, A_AUTO_ADR, 16'h0042, EXC_NONE);
    chk(o_cmd_data, 16'h0042);
    xfer(1'b1, A_PLANT_CMP, 16'h0051, EXC_NONE);
    chk(o_cmd_data, 16'h0051);
    @(posedge i_ref_clk);
    #1;
    chk(16'(n_auto), 16'h0001);
    chk(16'(n_plant), 16'h0001);
    xfer(1'b1, A_OUT_STATE, 16'h0003, EXC_NONE);
    chk({13'h0, o_out_cmd}, 16'h0003);
    pulse(1, 16'h1357, 5'h00);
    pulse(1, 16'h2468, 5'h10);
    chk({15'h0, o_restart_req}, 16'h0001);
    chk(o_cfg[15:0], 16'h0);
    pulse(2, 16'h0, 5'h0);
    chk(o_cfg[15:0], 16'h1357);
    chk(o_cfg[271:256], 16'h2468);
    chk({15'h0, o_restart_req}, 16'h0);
    pulse(0, PW_NATIVE, 5'h0);
    chk({15'h0, o_legacy_map}, 16'h0);
    m.access(1'b0, A_RUN_CTRL, 16'h0, rdata, exc, got);
    chk({15'h0, got}, 16'h0);
    @(posedge i_ref_clk);
    #1 i_resetn = 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1 i_resetn = 1'b1;
    chk({15'h0, o_run}, 16'h0);
    chk(o_offline_ms, 16'h0);
    chk(o_cfg[47:32], 16'h0);
    test_done();
  end
endmodule
